/* rtl/rsc_pkg.sv */
// Purpose: Shared constants and types of the reset source controller.
// Assumes: One core clock; a machine cycle is four states of that clock.
// Notes: Register offsets are byte addresses on a 32-bit APB.
package rsc_pkg;

  // Machine cycle framing.
  localparam int STATES_PER_MC = 4;
  localparam logic [1:0] FOURTH_STATE = 2'h3;

  // Reset timing, in machine cycles and in clock cycles.
  localparam int EXT_LOW_SAMPLES = 2;
  localparam int EXT_HOLD_MC = 2;
  localparam int WD_HOLD_MC = 2;
  localparam int EXT_HOLD_CYC = EXT_HOLD_MC * STATES_PER_MC;
  localparam int WD_HOLD_CYC = WD_HOLD_MC * STATES_PER_MC;
  localparam int WD_RST_DELAY_CYC = 512;

  // Register offsets.
  localparam logic [7:0] ADDR_WDCTL = 8'h00;
  localparam logic [7:0] ADDR_UNLOCK = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;

  // Field positions of watchdog_control.
  localparam int WD_RUN_BIT = 0;
  localparam int WD_RST_EN_BIT = 1;
  localparam int WD_RST_FLAG_BIT = 2;
  localparam int WD_TO_FLAG_BIT = 3;
  localparam int WD_SEL_LO_BIT = 4;
  localparam int WD_SEL_HI_BIT = 5;
  localparam int POR_FLAG_BIT = 6;
  localparam int WD_RESTART_BIT = 7;

  // Bits writable only inside the unlock window.
  localparam logic [7:0] WDCTL_LOCKED_MASK = 8'hBB;
  // Reset values of watchdog_control per source; a keep mask marks bits left alone.
  localparam logic [7:0] WDCTL_POR_VALUE = 8'h40;
  localparam logic [7:0] WDCTL_EXT_KEEP = 8'h54;
  localparam logic [7:0] WDCTL_WD_KEEP = 8'h50;
  localparam logic [7:0] WDCTL_WD_SET = 8'h04;

  // Core state loaded on every reset.
  localparam logic [7:0] PORT_RESET_VALUE = 8'hFF;
  localparam logic [7:0] SP_RESET_VALUE = 8'h07;
  localparam logic [15:0] PC_RESET_VALUE = 16'h0000;

  // Unlock sequence.
  localparam logic [7:0] UNLOCK_KEY1 = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h55;
  localparam int UNLOCK_WINDOW_CYC = 8;

  // Interrupt status bits.
  localparam int IRQ_EXT_RST = 0;
  localparam int IRQ_WD_TIMEOUT = 1;
  localparam int IRQ_WD_RST = 2;
  localparam int IRQ_POR = 3;
  localparam int IRQ_BITS = 4;

  typedef enum logic [1:0] {
    RSC_UNLOCK_IDLE = 2'b00,
    RSC_UNLOCK_HALF = 2'b01,
    RSC_UNLOCK_OPEN = 2'b10
  } rsc_unlock_e;

endpackage

/* rtl/rsc_reset_source_controller.sv */
// Purpose: Reset source controller with watchdog, cause flags and APB registers.
// Assumes: ref_clk runs at 10 MHz; rst_pin_n and power_good are asynchronous pins.
// Notes: On-chip RAM is never touched here; only the listed core state is reloaded.
//
// Notes on behaviour
// R1: Sample the external reset pin once per machine cycle, in the fourth state.
// R2: Pin must stay low two machine cycles; reset asserts after two low samples.
// R3: Stay in reset while pin low and two machine cycles after; restart at zero.
// R4: Pin reset is recognised only through clocked sampling, never while clock stops.
// R5: External reset sets no cause flag; both other flags clear identify it.
// R6: After power returns apply power-on delay and set the power-on flag.
// R7: Loss of power forces reset; a new power-on sequence follows recovery.
// R8: Watchdog counts the selected interval, sets timeout flag; software restart clears count.
// R9: With reset enable set and no restart, reset 512 clocks after timeout.
// R10: Watchdog reset holds two machine cycles, sets watchdog reset flag, restarts at zero.
// R11: After power-on reset the watchdog stays disabled.
// R12: Every reset loads ports with all ones, program counter zero, stack pointer seven.
// R13: Reset leaves on-chip RAM contents untouched.
// R14: Watchdog reset flag cleared by power-on reset, kept across external reset.
// R15: Every reset clears reset enable; timeout flag cleared by reset or software.
// R16: watchdog_control takes a reset value that depends on the reset source.
// R17: Watchdog bits writable only after unlock; the other bits freely writable.
// R18: Several sources together hold reset until last releases, with longest hold.
`timescale 1ns/10ps
module rsc_reset_source_controller #(
  parameter int POR_DELAY_CYC = 65536,
  parameter int WD_BASE_BITS = 17
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Pins from the outside world.
  input wire logic rst_pin_n,
  input wire logic power_good,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core control.
  output logic core_rst,
  output logic exec_start,
  output logic [15:0] pc_load_value,
  output logic [7:0] sp_load_value,
  output logic [7:0] port_load_value,
  output logic watchdog_run_out,
  // Interrupt.
  output logic irq
);

  localparam int HOLD_W = $clog2(POR_DELAY_CYC + 1) + 1;
  localparam int WD_W = WD_BASE_BITS + 10;

  initial begin
    if (POR_DELAY_CYC < rsc_pkg::EXT_HOLD_CYC || WD_BASE_BITS < 10 || WD_BASE_BITS > 20) begin
      $error("rsc_reset_source_controller: unsupported parameter values");
    end
  end

  function automatic logic [HOLD_W-1:0] hold_max(input logic [HOLD_W-1:0] a, input logic [HOLD_W-1:0] b);
    hold_max = (a > b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic rst_n_meta_reg;
  logic rst_n_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pg_meta_reg;
  logic pg_sync_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_n_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_n_meta_reg <= 1'b1;
      rst_n_reg <= rst_n_meta_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pg_meta_reg <= 1'b0;
      pg_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= rst_pin_n;
      pin_sync_reg <= pin_meta_reg;
      pg_meta_reg <= power_good;
      pg_sync_reg <= pg_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Machine cycle and external pin recognition.

  logic [1:0] state_reg;
  logic [1:0] low_cnt_reg;
  logic ext_active;
  logic ext_event;
  logic fourth;

  assign fourth = (state_reg == rsc_pkg::FOURTH_STATE);
  assign ext_active = (low_cnt_reg == 2'(rsc_pkg::EXT_LOW_SAMPLES));
  assign ext_event = fourth && !pin_sync_reg && (low_cnt_reg == 2'(rsc_pkg::EXT_LOW_SAMPLES - 1));

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= 2'h0;
    end else begin
      state_reg <= state_reg + 2'h1;
    end
  end

  // A stopped clock takes no sample, so the pin alone never resets the core. [R4]
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      low_cnt_reg <= 2'h0;
    end else if (fourth) begin // [R1]
      if (pin_sync_reg) begin
        low_cnt_reg <= 2'h0;
      end else if (!ext_active) begin
        low_cnt_reg <= low_cnt_reg + 2'h1; // [R2]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on source.

  logic por_pend_reg;
  logic por_active;

  // Controller release counts as a power-on; power loss re-enters it. [R7]
  assign por_active = por_pend_reg || !pg_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      por_pend_reg <= 1'b1;
    end else begin
      por_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog counter and delayed reset.

  logic [7:0] wdctl_reg;
  logic [WD_W-1:0] wd_cnt_reg;
  logic [9:0] wd_delay_reg;
  logic wd_pend_reg;
  logic wd_expire;
  logic wd_event;
  logic wd_restart;
  logic core_rst_reg;
  logic [1:0] wd_sel;

  assign wd_sel = {wdctl_reg[rsc_pkg::WD_SEL_HI_BIT], wdctl_reg[rsc_pkg::WD_SEL_LO_BIT]};
  assign wd_expire = wdctl_reg[rsc_pkg::WD_RUN_BIT] && !core_rst_reg &&
    (wd_cnt_reg == WD_W'((64'h1 << (WD_BASE_BITS + 3 * int'(wd_sel))) - 64'h1)); // [R8]
  assign wd_event = wd_pend_reg && !wd_restart &&
    (wd_delay_reg == 10'(rsc_pkg::WD_RST_DELAY_CYC - 1)) && wdctl_reg[rsc_pkg::WD_RST_EN_BIT]; // [R9]

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wd_cnt_reg <= '0;
    end else if (core_rst_reg || wd_restart || wd_expire || !wdctl_reg[rsc_pkg::WD_RUN_BIT]) begin
      wd_cnt_reg <= '0; // [R8]
    end else begin
      wd_cnt_reg <= wd_cnt_reg + WD_W'(1);
    end
  end

  // The delay runs from the timeout; a restart or any reset cancels it. [R9]
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wd_pend_reg <= 1'b0;
      wd_delay_reg <= 10'h000;
    end else if (core_rst_reg || wd_restart || wd_event) begin
      wd_pend_reg <= 1'b0;
      wd_delay_reg <= 10'h000;
    end else if (wd_expire) begin
      wd_pend_reg <= 1'b1;
      wd_delay_reg <= 10'h000;
    end else if (wd_pend_reg && wd_delay_reg != 10'(rsc_pkg::WD_RST_DELAY_CYC - 1)) begin
      wd_delay_reg <= wd_delay_reg + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Combined reset hold.

  logic [HOLD_W-1:0] hold_reg;
  logic [HOLD_W-1:0] hold_need;
  logic any_src;
  logic core_rst_next;

  always_comb begin
    hold_need = '0;
    if (ext_active) begin
      hold_need = hold_max(hold_need, HOLD_W'(rsc_pkg::EXT_HOLD_CYC)); // [R3]
    end
    if (wd_event) begin
      hold_need = hold_max(hold_need, HOLD_W'(rsc_pkg::WD_HOLD_CYC)); // [R10]
    end
    if (por_active) begin
      hold_need = hold_max(hold_need, HOLD_W'(POR_DELAY_CYC)); // [R6]
    end
  end

  assign any_src = ext_active || por_active || wd_event;
  assign core_rst_next = any_src || (hold_reg > HOLD_W'(1));

  // The longest pending hold wins and only starts once every source is gone. [R18]
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      hold_reg <= '0;
    end else if (any_src) begin
      hold_reg <= hold_max(hold_reg, hold_need);
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - HOLD_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      core_rst_reg <= 1'b1;
      exec_start <= 1'b0;
    end else begin
      core_rst_reg <= core_rst_next;
      exec_start <= core_rst_reg && !core_rst_next; // [R3]
    end
  end

  // Only pointer and port state is reloaded; RAM gets no write or clear here. [R13]
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pc_load_value <= rsc_pkg::PC_RESET_VALUE;
      sp_load_value <= rsc_pkg::SP_RESET_VALUE;
      port_load_value <= rsc_pkg::PORT_RESET_VALUE;
    end else if (core_rst_reg) begin
      pc_load_value <= rsc_pkg::PC_RESET_VALUE; // [R12]
      sp_load_value <= rsc_pkg::SP_RESET_VALUE;
      port_load_value <= rsc_pkg::PORT_RESET_VALUE;
    end
  end

  assign core_rst = core_rst_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode and unlock window.

  rsc_pkg::rsc_unlock_e unlock_reg;
  logic [3:0] unlock_cnt_reg;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic wr_wdctl;
  logic wr_unlock;
  logic unlocked;
  logic [7:0] wdata8;

  assign wdata8 = pwdata[7:0];
  assign mapped = (paddr == rsc_pkg::ADDR_WDCTL) || (paddr == rsc_pkg::ADDR_UNLOCK) ||
    (paddr == rsc_pkg::ADDR_IRQ_STAT) || (paddr == rsc_pkg::ADDR_IRQ_MASK) ||
    (paddr == rsc_pkg::ADDR_STATE);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_wdctl = wr_en && (paddr == rsc_pkg::ADDR_WDCTL);
  assign wr_unlock = wr_en && (paddr == rsc_pkg::ADDR_UNLOCK);
  assign unlocked = (unlock_reg == rsc_pkg::RSC_UNLOCK_OPEN);
  assign wd_restart = wr_wdctl && unlocked && wdata8[rsc_pkg::WD_RESTART_BIT];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // The window is short so that a stray write cannot open protected bits for long.
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      unlock_reg <= rsc_pkg::RSC_UNLOCK_IDLE;
      unlock_cnt_reg <= 4'h0;
    end else begin
      unique case (unlock_reg)
        rsc_pkg::RSC_UNLOCK_IDLE: begin
          if (wr_unlock && wdata8 == rsc_pkg::UNLOCK_KEY1) begin
            unlock_reg <= rsc_pkg::RSC_UNLOCK_HALF;
            unlock_cnt_reg <= 4'(rsc_pkg::UNLOCK_WINDOW_CYC);
          end
        end
        rsc_pkg::RSC_UNLOCK_HALF: begin
          if (wr_unlock && wdata8 == rsc_pkg::UNLOCK_KEY2) begin
            unlock_reg <= rsc_pkg::RSC_UNLOCK_OPEN;
            unlock_cnt_reg <= 4'(rsc_pkg::UNLOCK_WINDOW_CYC);
          end else if (wr_en || unlock_cnt_reg == 4'h0) begin
            unlock_reg <= rsc_pkg::RSC_UNLOCK_IDLE;
          end else begin
            unlock_cnt_reg <= unlock_cnt_reg - 4'h1;
          end
        end
        rsc_pkg::RSC_UNLOCK_OPEN: begin
          if (wr_wdctl || unlock_cnt_reg == 4'h0) begin
            unlock_reg <= rsc_pkg::RSC_UNLOCK_IDLE;
          end else begin
            unlock_cnt_reg <= unlock_cnt_reg - 4'h1;
          end
        end
        default: begin
          unlock_reg <= rsc_pkg::RSC_UNLOCK_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog control register.

  logic [7:0] wdctl_next;
  logic [7:0] wr_mask;

  always_comb begin
    wr_mask = unlocked ? 8'hFF : ~rsc_pkg::WDCTL_LOCKED_MASK; // [R17]
    wdctl_next = wdctl_reg;
    if (wr_wdctl) begin
      wdctl_next = (wdctl_reg & ~wr_mask) | (wdata8 & wr_mask);
      wdctl_next[rsc_pkg::WD_RESTART_BIT] = 1'b0;
    end
    if (wd_expire) begin
      wdctl_next[rsc_pkg::WD_TO_FLAG_BIT] = 1'b1; // [R8]
    end
    if (ext_event) begin
      wdctl_next = wdctl_reg & rsc_pkg::WDCTL_EXT_KEEP; // [R5] [R14] [R15] [R16]
    end
    if (wd_event) begin
      wdctl_next = (wdctl_reg & rsc_pkg::WDCTL_WD_KEEP) | rsc_pkg::WDCTL_WD_SET; // [R10] [R16]
    end
    if (por_active) begin
      wdctl_next = rsc_pkg::WDCTL_POR_VALUE; // [R6] [R11] [R14] [R16]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wdctl_reg <= rsc_pkg::WDCTL_POR_VALUE;
    end else begin
      wdctl_reg <= wdctl_next;
    end
  end

  assign watchdog_run_out = wdctl_reg[rsc_pkg::WD_RUN_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  logic [rsc_pkg::IRQ_BITS-1:0] irq_stat_reg;
  logic [rsc_pkg::IRQ_BITS-1:0] irq_mask_reg;
  logic [rsc_pkg::IRQ_BITS-1:0] irq_set;
  logic por_done;

  assign por_done = por_active && !core_rst_next;
  assign irq_set = {core_rst_reg && hold_reg == HOLD_W'(1) && wdctl_reg[rsc_pkg::POR_FLAG_BIT],
    wd_event, wd_expire, ext_event};

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_en && paddr == rsc_pkg::ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[rsc_pkg::IRQ_BITS-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr_en && paddr == rsc_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= pwdata[rsc_pkg::IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg) || por_done && 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase.

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      unique case (paddr)
        rsc_pkg::ADDR_WDCTL: prdata <= {24'h000000, wdctl_reg};
        rsc_pkg::ADDR_IRQ_STAT: prdata <= {28'h0000000, irq_stat_reg};
        rsc_pkg::ADDR_IRQ_MASK: prdata <= {28'h0000000, irq_mask_reg};
        rsc_pkg::ADDR_STATE: prdata <= {24'h000000, sp_load_value[3:0], 1'b0, wd_pend_reg,
          ext_active, core_rst_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

/* test/rsc_reset_source_controller_monitor.sv */
// Purpose: Concurrent checks on the ports of the reset source controller.
// Assumes: One ref_clk domain; nrst low disables every check.
// Notes: Saturating counters stand in for long repetitions.
`timescale 1ns/10ps
module rsc_reset_source_controller_monitor #(
  parameter int POR_DELAY_CYC = 65536,
  parameter int WD_BASE_BITS = 17
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Pins.
  input wire logic rst_pin_n,
  input wire logic power_good,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core control.
  input wire logic core_rst,
  input wire logic exec_start,
  input wire logic [15:0] pc_load_value,
  input wire logic [7:0] sp_load_value,
  input wire logic [7:0] port_load_value,
  input wire logic watchdog_run_out
);
  logic [4:0] low_cnt;
  logic [7:0] quiet_cnt;
  logic unmapped;
  assign unmapped = !(paddr inside {rsc_pkg::ADDR_WDCTL, rsc_pkg::ADDR_UNLOCK, rsc_pkg::ADDR_IRQ_STAT,
                                    rsc_pkg::ADDR_IRQ_MASK, rsc_pkg::ADDR_STATE});
  ////////////////////////////////////////////////////////////////////////////////
  // A long quiet span on both pins tells a watchdog reset apart from the others.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 5'h00;
    end else if (rst_pin_n) begin
      low_cnt <= 5'h00;
    end else if (low_cnt != 5'h1F) begin
      low_cnt <= low_cnt + 5'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      quiet_cnt <= 8'h00;
    end else if (!rst_pin_n || !power_good) begin
      quiet_cnt <= 8'h00;
    end else if (quiet_cnt != 8'hFF) begin
      quiet_cnt <= quiet_cnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence access_s;
    psel && penable;
  endsequence
  sequence wd_rise_s;
    $rose(core_rst) && quiet_cnt == 8'hFF;
  endsequence
  ext_hold_a: assert property (low_cnt == 5'h0F |-> core_rst)
    else $error("pin held low without core reset");
  reset_min_a: assert property ($rose(core_rst) |-> core_rst[*8])
    else $error("core reset shorter than two machine cycles");
  wd_release_a: assert property (wd_rise_s |-> ##[8:10] !core_rst)
    else $error("watchdog reset not released in time");
  exec_restart_a: assert property ($fell(core_rst) |-> exec_start)
    else $error("no execution start after reset");
  exec_pulse_a: assert property (exec_start |-> !core_rst ##1 !exec_start)
    else $error("execution start is not a single pulse");
  power_loss_a: assert property ((!power_good)[*6] |-> core_rst)
    else $error("power loss did not hold core reset");
  load_values_a: assert property (core_rst && $past(core_rst) |-> pc_load_value == rsc_pkg::PC_RESET_VALUE
    && sp_load_value == rsc_pkg::SP_RESET_VALUE && port_load_value == rsc_pkg::PORT_RESET_VALUE)
    else $error("core load values wrong in reset");
  run_cleared_a: assert property ($rose(core_rst) |-> ##3 (core_rst && !watchdog_run_out))
    else $error("watchdog still running in reset");
  unmapped_err_a: assert property (access_s and unmapped |-> pslverr && (pwrite || prdata == 32'h00000000))
    else $error("unmapped access not refused");
  err_cause_a: assert property (pslverr |-> access_s and unmapped)
    else $error("error without unmapped access");
endmodule
bind rsc_reset_source_controller rsc_reset_source_controller_monitor #(
  .POR_DELAY_CYC(POR_DELAY_CYC),
  .WD_BASE_BITS(WD_BASE_BITS)
) rsc_reset_source_controller_monitor_inst (
  .ref_clk(ref_clk), .nrst(nrst), .rst_pin_n(rst_pin_n), .power_good(power_good),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_rst(core_rst), .exec_start(exec_start),
  .pc_load_value(pc_load_value), .sp_load_value(sp_load_value),
  .port_load_value(port_load_value), .watchdog_run_out(watchdog_run_out)
);

/* test/rsc_supply_pin_model.sv */
// Purpose: Far side model: reset pin driver and supply supervisor.
// Assumes: Pins change only just after a rising clock edge.
// Notes: The pin idles high, as a pulled-up reset line does.
`timescale 1ns/10ps
module rsc_supply_pin_model (
  // Clock.
  input wire logic ref_clk,
  // Pins toward the device.
  output logic rst_pin_n,
  output logic power_good
);
  initial begin
    rst_pin_n = 1'b1;
    power_good = 1'b1;
  end
  // Counts of one machine cycle or less model a glitch that must be ignored.
  task automatic pin_low(input int cycles);
    @(posedge ref_clk);
    rst_pin_n <= 1'b0;
    repeat (cycles) @(posedge ref_clk);
    rst_pin_n <= 1'b1;
  endtask
  task automatic power_drop(input int cycles);
    @(posedge ref_clk);
    power_good <= 1'b0;
    repeat (cycles) @(posedge ref_clk);
    power_good <= 1'b1;
  endtask
endmodule

/* test/reset_source_controller_tb_top.sv */
// Purpose: Self-checking bench of the reset source controller.
// Assumes: Short power-on delay and watchdog base so the run stays brief.
// Notes: Registers are reached only through the APB tasks.
`timescale 1ns/10ps
module reset_source_controller_tb_top;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, core_rst, exec_start;
  logic watchdog_run_out, irq, rst_pin_n, power_good;
  logic [7:0] paddr, sp_load_value, port_load_value;
  logic [15:0] pc_load_value;
  logic [31:0] pwdata, prdata;
  int n_mismatch;
  int checks_done;
  rsc_reset_source_controller #(.POR_DELAY_CYC(16), .WD_BASE_BITS(10)) rsc_reset_source_controller_inst (
    .ref_clk(ref_clk), .nrst(nrst), .rst_pin_n(rst_pin_n), .power_good(power_good),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_rst(core_rst),
    .exec_start(exec_start), .pc_load_value(pc_load_value), .sp_load_value(sp_load_value),
    .port_load_value(port_load_value), .watchdog_run_out(watchdog_run_out), .irq(irq)
  );
  rsc_supply_pin_model rsc_supply_pin_model_inst (
    .ref_clk(ref_clk), .rst_pin_n(rst_pin_n), .power_good(power_good)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The master never gives up on pready; only the 10000-cycle bench time limit ends a hang.
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h00000000, r, e);
    check(r, exp);
  endtask
  task automatic unlock();
    wr(rsc_pkg::ADDR_UNLOCK, {24'h000000, rsc_pkg::UNLOCK_KEY1});
    wr(rsc_pkg::ADDR_UNLOCK, {24'h000000, rsc_pkg::UNLOCK_KEY2});
  endtask
  task automatic wait_for(input logic sel, input logic want, input int lim);
    int n;
    n = 0;
    while ((sel ? irq : core_rst) !== want && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h00000000, sel ? irq : core_rst}, {31'h00000000, want});
  endtask
  task automatic irq_after(input logic [7:0] a, input logic [31:0] d, input logic exp);
    wr(a, d);
    repeat (2) @(posedge ref_clk);
    check({31'h00000000, irq}, {31'h00000000, exp});
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (10000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    logic [31:0] r;
    logic e;
    n_mismatch = 0;
    checks_done = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_for(1'b0, 1'b0, 200);
    rd(rsc_pkg::ADDR_WDCTL, 32'h00000040);
    rd(rsc_pkg::ADDR_IRQ_STAT, 32'h00000008);
    wr(rsc_pkg::ADDR_IRQ_STAT, 32'h0000000F);
    xfer(1'b0, 8'h20, 32'h00000000, r, e);
    check({r[30:0], e}, 32'h00000001);
    wr(rsc_pkg::ADDR_WDCTL, 32'h000000FF);
    rd(rsc_pkg::ADDR_WDCTL, 32'h00000044);
    wr(rsc_pkg::ADDR_WDCTL, 32'h00000000);
    rd(rsc_pkg::ADDR_WDCTL, 32'h00000000);
    unlock();
    wr(rsc_pkg::ADDR_WDCTL, 32'h00000003);
    rd(rsc_pkg::ADDR_WDCTL, 32'h00000003);
    check({31'h00000000, watchdog_run_out}, 32'h00000001);
    wr(rsc_pkg::ADDR_IRQ_MASK, 32'h00000002);
    wait_for(1'b1, 1'b1, 1100);
    rd(rsc_pkg::ADDR_WDCTL, 32'h0000000B);
    repeat (480) @(posedge ref_clk);
    check({31'h00000000, core_rst}, 32'h00000000);
    wait_for(1'b0, 1'b1, 40);
    @(posedge ref_clk);
    check({pc_load_value, sp_load_value, port_load_value}, 32'h000007FF);
    wait_for(1'b0, 1'b0, 20);
    rd(rsc_pkg::ADDR_WDCTL, 32'h00000004);
    irq_after(rsc_pkg::ADDR_IRQ_MASK, 32'h00000000, 1'b0);
    irq_after(rsc_pkg::ADDR_IRQ_MASK, 32'h00000002, 1'b1);
    irq_after(rsc_pkg::ADDR_IRQ_STAT, 32'h0000000F, 1'b0);
    unlock();
    wr(rsc_pkg::ADDR_WDCTL, 32'h00000006);
    rsc_supply_pin_model_inst.pin_low(3);
    repeat (20) @(posedge ref_clk);
    check({31'h00000000, core_rst}, 32'h00000000);
    rsc_supply_pin_model_inst.pin_low(16);
    check({31'h00000000, core_rst}, 32'h00000001);
    wait_for(1'b0, 1'b0, 20);
    rd(rsc_pkg::ADDR_WDCTL, 32'h00000004);
    rsc_supply_pin_model_inst.power_drop(10);
    check({31'h00000000, core_rst}, 32'h00000001);
    wait_for(1'b0, 1'b0, 80);
    rd(rsc_pkg::ADDR_WDCTL, 32'h00000040);
    check({31'h00000000, watchdog_run_out}, 32'h00000000);
    report_and_stop();
  end
endmodule
